// ===== design/flash_ecc_training_protect.sv
// Training pattern, correction status and write protection of a serial flash.
// Assumes mode 0 serial frames; every frame has at least one link clock edge.
//
// Summary of operation
// RULE_01: Keep an 8-bit non-volatile training pattern, factory value zero.
// RULE_02: Power-on and reset load the volatile pattern from the non-volatile one.
// RULE_03: The pattern driven out comes from the volatile copy, writable anytime.
// RULE_04: Correction register has read, write and clear commands.
// RULE_05: Bit 0 disables correction when one; resets to zero.
// RULE_06: Bit 1 is a read-only flag set by a correction event.
// RULE_07: Bits 5 to 2 count corrections, saturating at fifteen.
// RULE_08: Bit 6 flags reprogram attempts; ignored while correction is enabled.
// RULE_09: Write-protect pin locks guard bits, status lock and quad enable.
// RULE_10: Status writes refused only when lock bit set and pin low.
// RULE_11: Program, erase and register writes need the write-enable latch.
// RULE_12: Four block guard bits protect part or all of the array.
// RULE_13: Sector guards still protect regions outside the block range.
// RULE_14: A region is protected if either scheme protects it.
// RULE_15: Host should use only one protection scheme at a time.
// RULE_16: Either sector guard bit at zero blocks program and erase.
// RULE_17: Clear command zeroes flags and tally, keeps the disable bit.
`timescale 1ns/1ps
module flash_ecc_training_protect (
    input wire logic clock, // Core clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic power_on, // Power-on reset, also restores factory pattern.
    input wire logic link_sck, // Serial link clock.
    input wire logic cs_n, // Frame select, active low.
    input wire logic mosi, // Serial data from host.
    output logic miso_out, // Serial data to host.
    output logic miso_oe, // Serial output enable.
    input wire logic write_protect_n, // Hardware write-protect pin, active low.
    input wire logic correction_pulse, // One-cycle pulse per corrected read.
    input wire logic [15:0] persistent_sector_guard, // Zero guards a region.
    input wire logic [15:0] dynamic_sector_guard, // Zero guards a region.
    input wire logic [15:0] region_programmed, // Region already holds data.
    output logic op_start, // Pulse: array operation accepted.
    output logic op_erase, // Accepted operation is an erase.
    output logic [3:0] op_region, // Region of the accepted operation.
    output logic op_refused // Pulse: program or erase refused.
);
    logic [4:0] bit_count_reg;
    logic [7:0] shift_reg;
    logic [7:0] cmd_reg;
    logic [7:0] data_reg;
    logic got_cmd_reg;
    logic got_data_reg;
    logic [7:0] out_reg;
    logic oe_reg;
    logic [7:0] cmd_next;
    logic [7:0] read_next;
    logic read_cmd;
    logic cs_meta_reg, cs_sync_reg, cs_prev_reg;
    logic wp_meta_reg, wp_sync_reg;
    logic frame_end;
    logic [7:0] status_reg;
    logic wel_reg;
    logic disable_reg, seen_reg, reprog_reg;
    logic [3:0] tally_reg;
    logic [7:0] stored_reg, live_reg;
    logic [7:0] snap_status_reg, snap_ecc_reg, snap_live_reg;
    logic [7:0] ecc_byte;
    logic is_cmd, do_prog, do_erase, do_clear, do_wrsr, wel_used;
    logic sr_writable, block_cover, sector_guarded, is_protected, occupied, op_ok;
    logic [3:0] region, guard;

    // Link side: counts bits of the frame and is cleared between frames.
    always_ff @(posedge link_sck or posedge cs_n) begin
        if (cs_n) begin
            bit_count_reg <= 5'h00;
        end else if (bit_count_reg != flash_pkg::BIT_COUNT_MAX) begin
            bit_count_reg <= bit_count_reg + 5'h01;
        end
    end

    assign cmd_next = {shift_reg[6:0], mosi};

    always_ff @(posedge link_sck) begin
        shift_reg <= cmd_next;
    end

    // Captured bytes stay stable once the frame ends, so the core reads them then.
    always_ff @(posedge link_sck) begin
        if (bit_count_reg == 5'h00) begin
            got_cmd_reg <= 1'b0;
            got_data_reg <= 1'b0;
        end else if (bit_count_reg == flash_pkg::BIT_CMD_LAST) begin
            cmd_reg <= cmd_next;
            got_cmd_reg <= 1'b1;
        end else if (bit_count_reg == flash_pkg::BIT_DATA_LAST) begin
            data_reg <= cmd_next;
            got_data_reg <= 1'b1;
        end
    end

    // Snapshots are frozen by the core while a frame is open.
    always_comb begin
        read_cmd = 1'b1;
        read_next = 8'h00;
        if (cmd_next == flash_pkg::CMD_ECC_READ) begin
            read_next = snap_ecc_reg; // see RULE_04
        end else if (cmd_next == flash_pkg::CMD_STATUS_READ) begin
            read_next = snap_status_reg;
        end else if (cmd_next == flash_pkg::CMD_PATTERN_READ ||
                     cmd_next == flash_pkg::CMD_TRAIN_READ) begin
            read_next = snap_live_reg; // see RULE_03
        end else begin
            read_cmd = 1'b0;
        end
    end

    always_ff @(posedge link_sck) begin
        if (bit_count_reg == flash_pkg::BIT_CMD_LAST) begin
            out_reg <= read_next;
        end else begin
            out_reg <= {out_reg[6:0], 1'b0};
        end
    end

    always_ff @(posedge link_sck or posedge cs_n) begin
        if (cs_n) begin
            oe_reg <= 1'b0;
        end else if (bit_count_reg == flash_pkg::BIT_CMD_LAST) begin
            oe_reg <= read_cmd;
        end
    end

    assign miso_out = out_reg[7];
    assign miso_oe = oe_reg;

    // Pin synchronisers into the core domain.
    always_ff @(posedge clock) begin
        cs_meta_reg <= cs_n;
        cs_sync_reg <= cs_meta_reg;
        cs_prev_reg <= cs_sync_reg;
        wp_meta_reg <= write_protect_n;
        wp_sync_reg <= wp_meta_reg;
    end

    assign frame_end = cs_sync_reg && !cs_prev_reg && !srst;

    // Command decode and protection check.
    always_comb begin
        is_cmd = frame_end && got_cmd_reg;
        do_prog = is_cmd && got_data_reg && cmd_reg == flash_pkg::CMD_PROGRAM;
        do_erase = is_cmd && got_data_reg && cmd_reg == flash_pkg::CMD_ERASE;
        do_clear = is_cmd && cmd_reg == flash_pkg::CMD_ECC_CLEAR; // see RULE_04
        do_wrsr = is_cmd && got_data_reg && cmd_reg == flash_pkg::CMD_STATUS_WRITE;
        wel_used = do_prog || do_erase || do_wrsr || (is_cmd && got_data_reg &&
            (cmd_reg == flash_pkg::CMD_ECC_WRITE || cmd_reg == flash_pkg::CMD_STORED_WRITE ||
             cmd_reg == flash_pkg::CMD_LIVE_WRITE));
        // Pin low with lock set freezes guard, lock and quad bits.
        sr_writable = !(status_reg[flash_pkg::STATUS_LOCK] && !wp_sync_reg); // see RULE_09 RULE_10
        region = data_reg[3:0];
        guard = status_reg[flash_pkg::STATUS_GUARD_HI:flash_pkg::STATUS_GUARD_LO];
        // Guard value n from 1 up covers the top n+1 regions; zero covers none, fifteen covers all of them.
        block_cover = (guard != flash_pkg::GUARD_NONE) &&
            (({1'b0, region} + {1'b0, guard}) >= flash_pkg::REGION_LAST); // see RULE_12
        sector_guarded = !persistent_sector_guard[region] ||
            !dynamic_sector_guard[region]; // see RULE_16 RULE_13
        is_protected = block_cover || sector_guarded; // see RULE_14
        occupied = do_prog && region_programmed[region];
        op_ok = wel_reg && !is_protected &&
            !(occupied && !disable_reg); // see RULE_11 RULE_08
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wel_reg <= 1'b0;
        end else if (is_cmd && cmd_reg == flash_pkg::CMD_WRITE_ENABLE) begin
            wel_reg <= 1'b1;
        end else if (wel_used || (is_cmd && cmd_reg == flash_pkg::CMD_WRITE_DISABLE)) begin
            wel_reg <= 1'b0; // see RULE_11
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            status_reg <= flash_pkg::STATUS_RESET;
        end else if (do_wrsr && wel_reg && sr_writable) begin
            status_reg <= data_reg; // see RULE_10
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            disable_reg <= 1'b0;
        end else if (is_cmd && got_data_reg && wel_reg &&
                     cmd_reg == flash_pkg::CMD_ECC_WRITE) begin
            disable_reg <= data_reg[flash_pkg::ECC_DISABLE]; // see RULE_05
        end
    end

    // A correction arriving with a clear is kept.
    always_ff @(posedge clock) begin
        if (srst) begin
            seen_reg <= 1'b0;
            tally_reg <= flash_pkg::TALLY_ZERO;
        end else if (do_clear) begin
            seen_reg <= correction_pulse; // see RULE_17
            tally_reg <= correction_pulse ? flash_pkg::TALLY_ONE : flash_pkg::TALLY_ZERO;
        end else if (correction_pulse) begin
            seen_reg <= 1'b1; // see RULE_06
            if (tally_reg != flash_pkg::TALLY_MAX) begin
                tally_reg <= tally_reg + flash_pkg::TALLY_ONE; // see RULE_07
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            reprog_reg <= 1'b0;
        end else if (occupied && wel_reg) begin
            reprog_reg <= 1'b1; // see RULE_08
        end else if (do_clear) begin
            reprog_reg <= 1'b0; // see RULE_17
        end
    end

    assign ecc_byte = {1'b0, reprog_reg, tally_reg, seen_reg, disable_reg};

    // Stored pattern survives ordinary reset; only power-on restores the factory value.
    always_ff @(posedge clock) begin
        if (power_on) begin
            stored_reg <= flash_pkg::PATTERN_FACTORY; // see RULE_01
        end else if (is_cmd && got_data_reg && wel_reg &&
                     cmd_reg == flash_pkg::CMD_STORED_WRITE) begin
            stored_reg <= data_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (power_on) begin
            live_reg <= flash_pkg::PATTERN_FACTORY;
        end else if (srst) begin
            live_reg <= stored_reg; // see RULE_02
        end else if (is_cmd && got_data_reg && wel_reg &&
                     cmd_reg == flash_pkg::CMD_LIVE_WRITE) begin
            live_reg <= data_reg; // see RULE_03
        end
    end

    // Snapshots follow the registers only while no frame is open.
    always_ff @(posedge clock) begin
        if (srst) begin
            snap_status_reg <= flash_pkg::STATUS_RESET;
            snap_ecc_reg <= 8'h00;
            snap_live_reg <= flash_pkg::PATTERN_FACTORY;
        end else if (cs_sync_reg) begin
            snap_status_reg <= status_reg;
            snap_ecc_reg <= ecc_byte;
            snap_live_reg <= live_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            op_start <= 1'b0;
            op_refused <= 1'b0;
            op_erase <= 1'b0;
            op_region <= 4'h0;
        end else begin
            op_start <= (do_prog || do_erase) && op_ok; // see RULE_14
            op_refused <= (do_prog || do_erase) && !op_ok;
            if (do_prog || do_erase) begin
                op_erase <= do_erase;
                op_region <= region;
            end
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (srst || power_on);

    property p_tally_sat;
        correction_pulse && !do_clear && tally_reg == flash_pkg::TALLY_MAX
            |=> tally_reg == flash_pkg::TALLY_MAX;
    endproperty
    a_tally_sat: assert property (p_tally_sat) else $error("tally left saturation"); // see RULE_07

    property p_tally_inc;
        correction_pulse && !do_clear && tally_reg != flash_pkg::TALLY_MAX
            |=> tally_reg == $past(tally_reg) + flash_pkg::TALLY_ONE;
    endproperty
    a_tally_inc: assert property (p_tally_inc) else $error("tally did not count"); // see RULE_07

    property p_seen;
        correction_pulse |=> seen_reg ##1 (seen_reg || $past(do_clear));
    endproperty
    a_seen: assert property (p_seen) else $error("correction flag not set"); // see RULE_06

    property p_clear;
        do_clear && !correction_pulse |=> !seen_reg && !reprog_reg &&
            tally_reg == flash_pkg::TALLY_ZERO && $stable(disable_reg);
    endproperty
    a_clear: assert property (p_clear) else $error("clear result wrong"); // see RULE_17

    property p_sr_lock;
        do_wrsr && status_reg[flash_pkg::STATUS_LOCK] && !wp_sync_reg |=> $stable(status_reg);
    endproperty
    a_sr_lock: assert property (p_sr_lock) else $error("locked status written"); // see RULE_10

    property p_wel;
        (do_prog || do_erase) && !wel_reg |=> !op_start && op_refused;
    endproperty
    a_wel: assert property (p_wel) else $error("operation without latch"); // see RULE_11

    property p_protect;
        op_start |-> !$past(is_protected) && $past(wel_reg);
    endproperty
    a_protect: assert property (p_protect) else $error("protected region opened"); // see RULE_14

    property p_reprog;
        occupied && !disable_reg |=> !op_start ##1 (reprog_reg || !$past(wel_reg, 2));
    endproperty
    a_reprog: assert property (p_reprog) else $error("reprogram not ignored"); // see RULE_08

    property p_live_reset;
        @(posedge clock) disable iff (power_on) srst && !power_on
            |=> live_reg == $past(stored_reg);
    endproperty
    a_live_reset: assert property (p_live_reset) else $error("live not loaded"); // see RULE_02

    property p_wel_set;
        is_cmd && cmd_reg == flash_pkg::CMD_WRITE_ENABLE |=> wel_reg;
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("latch not set"); // see RULE_11

    property p_ecc_write;
        is_cmd && got_data_reg && wel_reg && cmd_reg == flash_pkg::CMD_ECC_WRITE
            |=> disable_reg == $past(data_reg[flash_pkg::ECC_DISABLE]);
    endproperty
    a_ecc_write: assert property (p_ecc_write) else $error("bit not written"); // see RULE_05

    property p_live_write;
        is_cmd && got_data_reg && wel_reg && cmd_reg == flash_pkg::CMD_LIVE_WRITE
            |=> live_reg == $past(data_reg);
    endproperty
    a_live_write: assert property (p_live_write) else $error("live not written"); // see RULE_03

    property p_block_cover;
        (do_prog || do_erase) && block_cover |=> op_refused && !op_start;
    endproperty
    a_block_cover: assert property (p_block_cover) else $error("block opened"); // see RULE_12

    c_saturate: cover property (correction_pulse && tally_reg == flash_pkg::TALLY_MAX);
    c_start: cover property (op_start);
    c_locked: cover property (do_wrsr && !sr_writable);
    c_clear_race: cover property (do_clear && correction_pulse);
endmodule

// ===== design/flash_pkg.sv
// Constants shared by the serial flash protection and training logic.
// Assumes an 8-bit command byte followed by one optional data byte per frame.
package flash_pkg;
    // Command codes taken from the serial link.
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_STATUS_READ = 8'h05;
    localparam logic [7:0] CMD_ECC_READ = 8'hB3;
    localparam logic [7:0] CMD_ECC_WRITE = 8'hB5;
    localparam logic [7:0] CMD_ECC_CLEAR = 8'hB6;
    localparam logic [7:0] CMD_PATTERN_READ = 8'h41;
    localparam logic [7:0] CMD_STORED_WRITE = 8'h43;
    localparam logic [7:0] CMD_LIVE_WRITE = 8'h44;
    localparam logic [7:0] CMD_TRAIN_READ = 8'h0D;
    localparam logic [7:0] CMD_PROGRAM = 8'h02;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    // Link bit positions.
    localparam logic [4:0] BIT_CMD_LAST = 5'h07;
    localparam logic [4:0] BIT_DATA_LAST = 5'h0F;
    localparam logic [4:0] BIT_COUNT_MAX = 5'h1F;
    // Status register fields.
    localparam int STATUS_LOCK = 7;
    localparam int STATUS_QUAD = 6;
    localparam int STATUS_GUARD_HI = 5;
    localparam int STATUS_GUARD_LO = 2;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Correction control and status fields.
    localparam int ECC_DISABLE = 0;
    localparam logic [7:0] PATTERN_FACTORY = 8'h00;
    localparam logic [3:0] TALLY_MAX = 4'hF;
    localparam logic [3:0] TALLY_ONE = 4'h1;
    localparam logic [3:0] TALLY_ZERO = 4'h0;
    // Sixteen protection regions, the highest ones guarded first.
    localparam int REGION_COUNT = 16;
    localparam logic [4:0] REGION_LAST = 5'h0F;
    localparam logic [3:0] GUARD_NONE = 4'h0;
endpackage

// ===== sim/flash_ecc_training_protect_tb_top.sv
// Self-checking bench for the training, correction and protection block.
// Assumes the host model in spi_host_model.sv and the constants of flash_pkg.
`timescale 1ns/1ps
module flash_ecc_training_protect_tb_top;
    logic clock, srst, power_on, write_protect_n, correction_pulse;
    logic link_sck, cs_n, mosi, miso_out, miso_oe, op_start, op_erase, op_refused;
    logic [15:0] persistent_sector_guard, dynamic_sector_guard, region_programmed;
    logic [3:0] op_region;
    logic [7:0] rx;
    int n_errors = 0;
    int num_checks = 0;
    flash_ecc_training_protect dut (.clock(clock), .srst(srst), .power_on(power_on),
        .link_sck(link_sck), .cs_n(cs_n), .mosi(mosi), .miso_out(miso_out),
        .miso_oe(miso_oe), .write_protect_n(write_protect_n),
        .correction_pulse(correction_pulse), .persistent_sector_guard(persistent_sector_guard),
        .dynamic_sector_guard(dynamic_sector_guard), .region_programmed(region_programmed),
        .op_start(op_start), .op_erase(op_erase), .op_region(op_region),
        .op_refused(op_refused));
    spi_host_model host (.link_sck(link_sck), .cs_n(cs_n), .mosi(mosi),
        .miso_out(miso_out), .miso_oe(miso_oe));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic clocks(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Each frame is followed by 8 clocks so the command lands before the next one.
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] data, input int nbits);
        host.frame(cmd, data, nbits, rx);
        clocks(8);
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
        xfer(flash_pkg::CMD_WRITE_ENABLE, 8'h00, 8);
        xfer(cmd, data, 16);
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
        xfer(cmd, 8'h00, 16);
        check(rx, exp);
    endtask
    task automatic do_reset(input logic por);
        srst <= 1'b1;
        power_on <= por;
        clocks(2);
        srst <= 1'b0;
        power_on <= 1'b0;
        clocks(3);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clock);
            correction_pulse <= 1'b1;
            @(posedge clock);
            correction_pulse <= 1'b0;
        end
        clocks(4);
    endtask
    // Expected code: 2'b10 accepted, 2'b01 refused, 2'b00 ignored.
    task automatic op(input logic [7:0] cmd, input logic [3:0] rg, input logic write_enable_cmd,
            input logic [1:0] exp);
        logic [1:0] got;
        got = 2'b00;
        if (write_enable_cmd)
            xfer(flash_pkg::CMD_WRITE_ENABLE, 8'h00, 8);
        host.frame(cmd, {4'h0, rg}, 16, rx);
        for (int i = 0; i < 12 && got == 2'b00; i++) begin
            @(posedge clock);
            #1 got = {op_start, op_refused};
        end
        check({6'h00, got}, {6'h00, exp});
        if (exp != 2'b00 && got == 2'b00)
            wrap_up;
        if (exp != 2'b00)
            check({3'h0, op_erase, op_region}, {3'h0, cmd == flash_pkg::CMD_ERASE, rg});
        clocks(8);
    endtask
    task automatic t_defaults;
        rd(flash_pkg::CMD_ECC_READ, 8'h00);
        rd(flash_pkg::CMD_PATTERN_READ, flash_pkg::PATTERN_FACTORY);
        rd(flash_pkg::CMD_STATUS_READ, flash_pkg::STATUS_RESET);
    endtask
    task automatic t_pattern;
        wr(flash_pkg::CMD_STORED_WRITE, 8'hA5);
        wr(flash_pkg::CMD_LIVE_WRITE, 8'h3C);
        rd(flash_pkg::CMD_PATTERN_READ, 8'h3C);
        rd(flash_pkg::CMD_TRAIN_READ, 8'h3C);
        xfer(flash_pkg::CMD_LIVE_WRITE, 8'hFF, 16);
        rd(flash_pkg::CMD_PATTERN_READ, 8'h3C);
        do_reset(1'b0);
        rd(flash_pkg::CMD_PATTERN_READ, 8'hA5);
        do_reset(1'b1);
        rd(flash_pkg::CMD_PATTERN_READ, 8'h00);
    endtask
    task automatic t_ecc;
        pulses(1);
        rd(flash_pkg::CMD_ECC_READ, 8'h06);
        pulses(14);
        rd(flash_pkg::CMD_ECC_READ, 8'h3E);
        pulses(1);
        rd(flash_pkg::CMD_ECC_READ, 8'h3E);
        wr(flash_pkg::CMD_ECC_WRITE, 8'hFF);
        rd(flash_pkg::CMD_ECC_READ, 8'h3F);
        xfer(flash_pkg::CMD_ECC_CLEAR, 8'h00, 8);
        rd(flash_pkg::CMD_ECC_READ, 8'h01);
        wr(flash_pkg::CMD_ECC_WRITE, 8'h00);
        rd(flash_pkg::CMD_ECC_READ, 8'h00);
    endtask
    // Bit 1 of the case number is the lock bit, bit 0 the pin level.
    task automatic t_status;
        logic [7:0] keep;
        for (int c = 0; c < 4; c++) begin
            keep = c[1] ? 8'h80 : 8'h00;
            write_protect_n <= 1'b1;
            wr(flash_pkg::CMD_STATUS_WRITE, keep);
            write_protect_n <= c[0];
            wr(flash_pkg::CMD_STATUS_WRITE, 8'h7C);
            rd(flash_pkg::CMD_STATUS_READ, (c == 2) ? keep : 8'h7C);
        end
        write_protect_n <= 1'b1;
        wr(flash_pkg::CMD_STATUS_WRITE, 8'h00);
    endtask
    // Block guard 1 covers regions 14 and 15; sector guards cover 3, 5 and 14.
    // Block guards are dropped again after the sector-only cases, before the region 2 cases.
    task automatic t_array;
        wr(flash_pkg::CMD_STATUS_WRITE, 8'h04);
        persistent_sector_guard <= 16'hFFF7;
        dynamic_sector_guard <= 16'hBFDF;
        op(flash_pkg::CMD_PROGRAM, 4'hF, 1'b1, 2'b01);
        op(flash_pkg::CMD_ERASE, 4'hE, 1'b1, 2'b01);
        op(flash_pkg::CMD_PROGRAM, 4'h3, 1'b1, 2'b01);
        op(flash_pkg::CMD_ERASE, 4'h5, 1'b1, 2'b01);
        wr(flash_pkg::CMD_STATUS_WRITE, 8'h00);
        op(flash_pkg::CMD_ERASE, 4'h2, 1'b1, 2'b10);
        op(flash_pkg::CMD_PROGRAM, 4'h2, 1'b0, 2'b01);
        region_programmed <= 16'h0004;
        op(flash_pkg::CMD_PROGRAM, 4'h2, 1'b1, 2'b01);
        rd(flash_pkg::CMD_ECC_READ, 8'h40);
        wr(flash_pkg::CMD_ECC_WRITE, 8'h01);
        op(flash_pkg::CMD_PROGRAM, 4'h2, 1'b1, 2'b10);
        xfer(flash_pkg::CMD_ECC_CLEAR, 8'h00, 8);
        rd(flash_pkg::CMD_ECC_READ, 8'h01);
    endtask
    initial begin
        srst = 1'b1;
        power_on = 1'b1;
        write_protect_n = 1'b1;
        correction_pulse = 1'b0;
        persistent_sector_guard = 16'hFFFF;
        dynamic_sector_guard = 16'hFFFF;
        region_programmed = 16'h0000;
        clocks(8);
        srst <= 1'b0;
        power_on <= 1'b0;
        clocks(3);
        t_defaults;
        t_pattern;
        t_ecc;
        t_status;
        t_array;
        wrap_up;
    end
endmodule

// ===== sim/spi_host_model.sv
// Host side of the serial link: mode 0 frames on a link clock that stops between frames.
// Assumes the device samples mosi on rising link_sck and shifts miso out after it.
`timescale 1ns/1ps
module spi_host_model (
    output logic link_sck, // Link clock, low outside frames.
    output logic cs_n, // Frame select, active low.
    output logic mosi, // Host data.
    input wire logic miso_out, // Device data.
    input wire logic miso_oe // Device output enable.
);
    initial begin
        link_sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // A reply bit taken while the device is not driving reads as unknown.
    task automatic frame(input logic [7:0] cmd, input logic [7:0] data, input int nbits,
            output logic [7:0] rx);
        logic [15:0] tx;
        tx = {cmd, data};
        rx = 8'hXX;
        #13 cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            mosi = tx[15 - i];
            #32 link_sck = 1'b1;
            #32 link_sck = 1'b0;
            if (i >= 7 && i <= 14)
                rx[14 - i] = miso_oe ? miso_out : 1'bx;
        end
        #32 cs_n = 1'b1;
        // The released line must not keep showing the last bit.
        mosi = ~mosi;
    endtask
endmodule
